// *** logic/smc_mode_decode.sv ***
// Decoder of the three-bit low-power mode field into one-hot selects
`timescale 1ns/10ps
module smc_mode_decode
  import smc_pkg::*;
(
  input  wire logic [2:0] mode_in,
  output logic            stop_out,
  output logic            sleep_out,
  output logic            idle_out,
  output logic            rsvd_out
);

  // Reserved codes select none of stop, sleep and idle; they raise rsvd_out
  always_comb
  begin
    stop_out  = 1'b0;
    sleep_out = 1'b0;
    idle_out  = 1'b0;
    rsvd_out  = 1'b0;
    case (mode_in)
      SMC_MODE_STOP:  stop_out  = 1'b1;
      SMC_MODE_SLEEP: sleep_out = 1'b1;
      SMC_MODE_IDLE:  idle_out  = 1'b1;
      default:        rsvd_out  = 1'b1;
    endcase
  end

endmodule

// *** logic/smc_pkg.sv ***
// Package of offsets, field positions, reset values and mode codes for standby control
package smc_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register map
  localparam logic [11:0] CTRL_WORD_OFFS = 12'h000;

  // Field positions
  localparam int unsigned MODE_LSB  = 0;
  localparam int unsigned MODE_MSB  = 2;
  localparam int unsigned FAST_BIT  = 8;
  localparam int unsigned SLOW_BIT  = 9;
  localparam int unsigned PIN_BIT   = 16;
  localparam int unsigned RSVD_BIT  = 17;

  // Mode codes
  typedef enum logic [2:0] {
    SMC_MODE_STOP  = 3'h1,
    SMC_MODE_SLEEP = 3'h2,
    SMC_MODE_IDLE  = 3'h3
  } smc_mode_e;

  // Reset values
  localparam logic [2:0]  MODE_RST = 3'h3;
  localparam logic        FAST_RST = 1'b1;
  localparam logic        SLOW_RST = 1'b0;
  localparam logic        PIN_RST  = 1'b0;
  localparam logic        RSVD_RST = 1'b0;

endpackage

// *** logic/smc_standby_ctrl.sv ***
// Standby control register with APB slave and decoded mode outputs
//
// Summary of operation
// - Mode field bits 2:0: 001 stop, 010 sleep, 011 idle; resets idle.
// - Bit 8 keeps fast oscillator running after stop release; resets 1.
// - Bit 9 keeps slow oscillator running after stop release; resets 0.
// - Bit 16 makes pins inactive during stop when set; resets 0.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module smc_standby_ctrl
  import smc_pkg::*;
(
  input  wire logic                       core_clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       clk_en_in,
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [smc_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]                pwdata_in,
  input  wire logic [3:0]                 pstrb_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  output logic      [2:0]                 low_power_mode_select_out,
  output logic                            mode_stop_out,
  output logic                            mode_sleep_out,
  output logic                            mode_idle_out,
  output logic                            mode_reserved_out,
  output logic                            fast_osc_after_wake_out,
  output logic                            slow_osc_after_wake_out,
  output logic                            pin_hold_in_deep_halt_out
);

  import smc_pkg::*;

  logic [2:0] mode_r;
  logic       fast_r;
  logic       slow_r;
  logic       pin_r;
  logic       rsvd_r;
  logic       hit;
  logic       setup;
  logic       wr_en;
  logic       dec_stop;
  logic       dec_sleep;
  logic       dec_idle;
  logic       dec_rsvd;
  logic [31:0] rd_word;

  // Aligned word decode; setup phase only, so access answers one cycle later
  assign hit   = (paddr_in[ADDR_W-1:2] == CTRL_WORD_OFFS[ADDR_W-1:2]);
  assign setup = psel_in && !penable_in;
  assign wr_en = clk_en_in && psel_in && penable_in && pready_out && pwrite_in && hit;

  // Ready pulses in the access phase; a wait state is never inserted
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      pready_out <= 1'b0;
    else if (clk_en_in)
      pready_out <= setup;
  end

  // Error answer for any unmapped address
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      pslverr_out <= 1'b0;
    else if (clk_en_in)
      pslverr_out <= setup && !hit;
  end

  // Mode field, byte lane 0
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      mode_r <= MODE_RST;
    else if (wr_en && pstrb_in[0])
      mode_r <= pwdata_in[MODE_MSB:MODE_LSB];
  end

  // Oscillator choices after stop release, byte lane 1
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      fast_r <= FAST_RST;
      slow_r <= SLOW_RST;
    end
    else if (wr_en && pstrb_in[1])
    begin
      fast_r <= pwdata_in[FAST_BIT];
      slow_r <= pwdata_in[SLOW_BIT];
    end
  end

  // Pin state in stop and the must-be-zero bit, byte lane 2
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      pin_r  <= PIN_RST;
      rsvd_r <= RSVD_RST;
    end
    else if (wr_en && pstrb_in[2])
    begin
      pin_r  <= pwdata_in[PIN_BIT];
      rsvd_r <= pwdata_in[RSVD_BIT];
    end
  end

  // Read word; all unused positions are zero
  always_comb
  begin
    rd_word                    = 32'h0000_0000;
    rd_word[MODE_MSB:MODE_LSB] = mode_r;
    rd_word[FAST_BIT]          = fast_r;
    rd_word[SLOW_BIT]          = slow_r;
    rd_word[PIN_BIT]           = pin_r;
    rd_word[RSVD_BIT]          = rsvd_r;
  end

  // Read data registered at setup so it stands during access
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      prdata_out <= 32'h0000_0000;
    else if (clk_en_in)
      prdata_out <= (setup && !pwrite_in && hit) ? rd_word : 32'h0000_0000;
  end

  smc_mode_decode u_dec (
    .mode_in   (mode_r),
    .stop_out  (dec_stop),
    .sleep_out (dec_sleep),
    .idle_out  (dec_idle),
    .rsvd_out  (dec_rsvd)
  );

  // Registered outputs lag the register by one cycle, keeping outputs glitch free
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      low_power_mode_select_out <= MODE_RST;
      mode_stop_out             <= 1'b0;
      mode_sleep_out            <= 1'b0;
      mode_idle_out             <= 1'b1;
      mode_reserved_out         <= 1'b0;
      fast_osc_after_wake_out   <= FAST_RST;
      slow_osc_after_wake_out   <= SLOW_RST;
      pin_hold_in_deep_halt_out <= PIN_RST;
    end
    else if (clk_en_in)
    begin
      low_power_mode_select_out <= mode_r;
      mode_stop_out             <= dec_stop;
      mode_sleep_out            <= dec_sleep;
      mode_idle_out             <= dec_idle;
      mode_reserved_out         <= dec_rsvd;
      fast_osc_after_wake_out   <= fast_r;
      slow_osc_after_wake_out   <= slow_r;
      pin_hold_in_deep_halt_out <= pin_r;
    end
  end

endmodule

// *** testbench/smc_standby_props.sv ***
// Checker of standby control outputs
`timescale 1ns/10ps
module smc_standby_props (
  input wire logic        core_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        pready_out,
  input wire logic [31:0] prdata_out,
  input wire logic [2:0]  low_power_mode_select_out,
  input wire logic        mode_stop_out,
  input wire logic        mode_sleep_out,
  input wire logic        mode_idle_out,
  input wire logic        mode_reserved_out,
  input wire logic        fast_osc_after_wake_out,
  input wire logic        slow_osc_after_wake_out,
  input wire logic        pin_hold_in_deep_halt_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Decode must match the stored field
  a_mode_decode: assert property (mode_stop_out == (low_power_mode_select_out == 3'h1)
    && mode_sleep_out == (low_power_mode_select_out == 3'h2) && mode_idle_out == (low_power_mode_select_out == 3'h3)
    && mode_reserved_out == !(low_power_mode_select_out inside {3'h1, 3'h2, 3'h3})) else $error("bad decode");
  a_reset_values: assert property ($fell(sys_rst_in) |-> low_power_mode_select_out == 3'h3
    && fast_osc_after_wake_out && !slow_osc_after_wake_out && !pin_hold_in_deep_halt_out) else $error("bad reset");
  // Fields move only after a completed transfer
  // Output follows the write edge by one cycle, so the access phase lies two samples back
  a_fast_write: assert property ($changed(fast_osc_after_wake_out) |-> $past(pready_out, 2)) else $error("fast moved");
  a_slow_write: assert property ($changed(slow_osc_after_wake_out) |-> $past(pready_out, 2)) else $error("slow moved");
  a_pin_write: assert property ($changed(pin_hold_in_deep_halt_out) |-> $past(pready_out, 2)) else $error("pin moved");
  a_unused_zero: assert property (pready_out |-> (prdata_out & 32'hFFFC_FCF8) == 32'h0) else $error("unused set");
  c_stop: cover property (mode_stop_out);
  c_rsvd: cover property (mode_reserved_out);
  c_pin: cover property (pin_hold_in_deep_halt_out);
endmodule
bind smc_standby_ctrl smc_standby_props i_props (.core_clk_in, .sys_rst_in, .pready_out, .prdata_out,
  .low_power_mode_select_out, .mode_stop_out, .mode_sleep_out, .mode_idle_out, .mode_reserved_out,
  .fast_osc_after_wake_out, .slow_osc_after_wake_out, .pin_hold_in_deep_halt_out);

// *** testbench/tb_top.sv ***
// Self-checking bench for the standby control register
`timescale 1ns/10ps
module tb_top;
  import smc_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, prdy, perr;
  logic [11:0] pa = '0;
  logic [31:0] pd = '0, prd, d;
  logic [3:0]  ps = '0;
  logic [2:0]  msel;
  logic [3:0]  dec;
  logic        fst, slw, pin;
  logic [32:0] q[$];
  int          fail_count = 0, check_count = 0;
  always #5 clk = ~clk;
  smc_standby_ctrl i_dut (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pd), .pstrb_in(ps), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .low_power_mode_select_out(msel), .mode_stop_out(dec[0]), .mode_sleep_out(dec[1]),
    .mode_idle_out(dec[2]), .mode_reserved_out(dec[3]), .fast_osc_after_wake_out(fst),
    .slow_osc_after_wake_out(slw), .pin_hold_in_deep_halt_out(pin));
  task chk(input logic [32:0] s, input logic [32:0] e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; read expectations go to the queue first
  task xf(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s, input logic [32:0] e);
    if (!w)
      q.push_back(e);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pd <= dd;
    ps <= s;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    psel <= 0;
    pen <= 0;
  endtask
  // Read answers compared in arrival order
  always @(posedge clk)
    if (prdy && psel && pen && !pwr)
      chk({perr, prd}, q.pop_front());
  // Sequence of tests
  initial
  begin
    void'($urandom(32'h3C4B70BE));
    repeat (5) @(posedge clk);
    rst <= 0;
    xf(0, CTRL_WORD_OFFS, '0, 4'hF, 33'h0_0000_0103);
    chk(33'({dec, pin, slw, fst}), 33'(7'b0100_001));
    $display("test reset done");
    for (int m = 1; m < 4; m++)
    begin
      d = ($urandom & 32'h0001_0300) | m;
      xf(1, CTRL_WORD_OFFS, d, 4'hF, '0);
      xf(0, CTRL_WORD_OFFS, '0, 4'hF, {1'b0, d});
      chk(33'(msel), 33'(m));
      chk(33'(dec), 33'(4'b0001 << (m - 1)));
      chk(33'({pin, slw, fst}), 33'({d[16], d[9], d[8]}));
    end
    $display("test modes done");
    // Every writable field set (bit 17 kept zero, valid mode), then a single-lane write
    xf(1, CTRL_WORD_OFFS, 32'h0001_0301, 4'hF, '0);
    xf(0, CTRL_WORD_OFFS, '0, 4'hF, 33'h0_0001_0301);
    xf(1, CTRL_WORD_OFFS, 32'h0000_0002, 4'h1, '0);
    xf(0, CTRL_WORD_OFFS, '0, 4'hF, 33'h0_0001_0302);
    xf(1, 12'h004, '0, 4'hF, '0);
    xf(0, 12'h004, '0, 4'hF, 33'h1_0000_0000);
    xf(0, CTRL_WORD_OFFS, '0, 4'hF, 33'h0_0001_0302);
    chk(33'({dec, pin, slw, fst}), 33'(7'b0010_111));
    $display("test lanes done");
    // Reset in mid-run restores defaults
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    xf(0, CTRL_WORD_OFFS, '0, 4'hF, 33'h0_0000_0103);
    chk(33'({dec, pin, slw, fst}), 33'(7'b0100_001));
    $display("test rereset done");
    @(posedge clk);
    report_and_stop();
  end
  // Watchdog far beyond the roughly 55 cycles needed
  initial
  begin
    #20000;
    fail_count++;
    report_and_stop();
  end
endmodule
